// ---- bench/acf_analog_model.sv ----
// behavioural analog side: comparator facing the successive-approximation logic
`timescale 1ns/100ps
`default_nettype none
module acf_analog_model (
  input wire logic clk_i,
  input wire logic [9:0] vin_i,
  input wire logic sar_active_i,
  input wire logic [9:0] trial_i,
  output logic compare_o
);
  // ========
  // comparator
  logic idle_r = 1'b0;
  // outside a conversion the comparator output means nothing, so it keeps moving
  always @(posedge clk_i) idle_r <= ~idle_r;
  assign compare_o = sar_active_i ? (trial_i <= vin_i) : idle_r;
endmodule
`default_nettype wire

// ---- bench/acf_core_tb.sv ----
// self-checking testbench of the converter control and result formatting block
`timescale 1ns/100ps
`default_nettype none
module acf_core_tb;
  localparam int ACQ_P [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  localparam int DIV_P [8] = '{2, 8, 32, acf_pkg::RC_DIV, 4, 16, 64, acf_pkg::RC_DIV};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ctu_trig = 1'b0;
  logic ccu_trig = 1'b0;
  logic [9:0] vin = 10'h000;
  logic [9:0] last = 10'h000;
  logic [7:0] rdata_o;
  logic compare_i, hold_connect_o, hold_discharge_o, sar_active_o, go_o;
  logic [9:0] sar_trial_o;
  logic [1:0] pos_ref_o, neg_ref_o;
  int err_total = 0;
  int checked = 0;

  acf_core u_acf_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .charge_time_unit_trig_i(ctu_trig),
    .capture_compare_unit_five_trig_i(ccu_trig), .compare_i(compare_i),
    .hold_connect_o(hold_connect_o), .hold_discharge_o(hold_discharge_o),
    .sar_active_o(sar_active_o), .sar_trial_o(sar_trial_o), .pos_ref_o(pos_ref_o),
    .neg_ref_o(neg_ref_o), .go_o(go_o));
  acf_analog_model u_acf_analog_model (.clk_i(clk_i), .vin_i(vin), .sar_active_i(sar_active_o),
    .trial_i(sar_trial_o), .compare_o(compare_i));

  always #5 clk_i = ~clk_i;

  // ========
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(16'(rdata_o), 16'(exp));
  endtask

  // one started conversion: phase lengths in clocks, then the stored result
  task automatic conv(input logic [7:0] c2, input logic [9:0] v, input int acq, input int div);
    int h, s, d, n, eh;
    h = 0;
    s = 0;
    d = 0;
    vin <= v;
    wr(3'h1, c2);
    wr(3'h4, 8'h03);
    for (n = 0; n < 4000; n++) begin
      @(posedge clk_i);
      #1;
      if (n == 0)
        check(16'(go_o), 16'h0001);
      h += hold_connect_o;
      s += sar_active_o;
      d += hold_discharge_o;
      if (d > 0 && !hold_discharge_o)
        break;
    end
    eh = acq * div + ((c2[1:0] == 2'b11) ? acf_pkg::INSTR_CYCLES : 0);
    check(inr(h, eh - 1, eh + div + 1), 16'h0001);
    check(inr(s, 10 * div - 1, 11 * div + 1), 16'h0001);
    check(inr(d, 2 * div - 1, 2 * div + 1), 16'h0001);
    check(16'(go_o), 16'h0000);
    if (c2[7]) begin
      rd(3'h2, {6'h00, v[9:8]});
      rd(3'h3, v[7:0]);
    end else begin
      rd(3'h2, v[9:2]);
      rd(3'h3, {v[1:0], 6'h00});
    end
    last = v;
  endtask

  task automatic trig(input logic which, input logic exp);
    @(posedge clk_i);
    if (which)
      ctu_trig <= 1'b1;
    else
      ccu_trig <= 1'b1;
    @(posedge clk_i);
    ctu_trig <= 1'b0;
    ccu_trig <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check(16'(go_o), 16'(exp));
  endtask

  // ========
  // scenarios
  task automatic regs_test;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'h8F);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'hBF);
    rd(3'h6, 8'h00);
    rd(3'h5, 8'h00);
  endtask

  task automatic refs_test;
    logic [1:0] pe [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    logic [1:0] ne [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
    for (int k = 0; k < 4; k++) begin
      wr(3'h0, {4'h0, k[1:0], k[1:0]});
      repeat (2) @(posedge clk_i);
      #1;
      check(16'(pos_ref_o), 16'(pe[k]));
      check(16'(neg_ref_o), 16'(ne[k]));
    end
  endtask

  task automatic acq_test;
    wr(3'h4, 8'h01);
    for (int k = 0; k < 8; k++)
      conv({k[0], 1'b0, k[2:0], 3'b000}, 10'(k * 93 + 5), ACQ_P[k], 2);
  endtask

  task automatic clk_test;
    for (int k = 0; k < 8; k++)
      conv({1'b1, 1'b0, 3'b001, k[2:0]}, 10'(1000 - k * 77), 2, DIV_P[k]);
  endtask

  // abort in mid-acquisition must leave the earlier result in place
  task automatic abort_test;
    vin <= 10'h155;
    wr(3'h1, 8'h3A);
    wr(3'h4, 8'h03);
    repeat (20) @(posedge clk_i);
    wr(3'h4, 8'h00);
    repeat (3) @(posedge clk_i);
    #1;
    check(16'(go_o), 16'h0000);
    rd(3'h2, last[9:2]);
    rd(3'h3, {last[1:0], 6'h00});
    rd(3'h4, 8'h00);
    repeat (200) @(posedge clk_i);
  endtask

  task automatic trig_test;
    wr(3'h1, 8'h08);
    wr(3'h0, 8'h00);
    trig(1'b0, 1'b0);
    wr(3'h4, 8'h01);
    trig(1'b1, 1'b0);
    trig(1'b0, 1'b1);
    rd(3'h4, 8'h03);
    repeat (60) @(posedge clk_i);
    wr(3'h0, 8'h80);
    trig(1'b0, 1'b0);
    trig(1'b1, 1'b1);
    repeat (60) @(posedge clk_i);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #600_000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    regs_test();
    refs_test();
    acq_test();
    clk_test();
    abort_test();
    trig_test();
    end_sim();
  end
endmodule
`default_nettype wire

// ---- rtl/acf_clock_div.sv ----
// conversion clock divider: one-cycle enable per conversion clock period
`timescale 1ns/100ps
`default_nettype none
module acf_clock_div #(
  parameter int RC_DIV = acf_pkg::RC_DIV
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sel_i,
  input wire logic restart_i,
  output logic tick_o,
  output logic rc_sel_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] limit;
  logic tick_nxt;

  // ==========================================================
  // divide ratios, minus one
  always_comb begin
    unique case (sel_i)
      3'h0: limit = 8'h01;
      3'h1: limit = 8'h07;
      3'h2: limit = 8'h1F;
      3'h4: limit = 8'h03;
      3'h5: limit = 8'h0F;
      3'h6: limit = 8'h3F;
      default: limit = 8'(RC_DIV - 1);
    endcase
    rc_sel_o = (sel_i[1:0] == 2'h3);
  end

  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    tick_nxt = 1'b0;
    if (restart_i) begin
      cnt_nxt = 8'h00;
    end else if (cnt_r >= limit) begin
      cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/acf_core.sv ----
// converter control and result formatting, top level
`timescale 1ns/100ps
`default_nettype none
module acf_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic charge_time_unit_trig_i,
  input wire logic capture_compare_unit_five_trig_i,
  input wire logic compare_i,
  output logic hold_connect_o,
  output logic hold_discharge_o,
  output logic sar_active_o,
  output logic [9:0] sar_trial_o,
  output logic [1:0] pos_ref_o,
  output logic [1:0] neg_ref_o,
  output logic go_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_ACQ,
    ST_CONV,
    ST_GAP
  } acf_state_type;

  // ==========================================================
  // registers
  logic [7:0] ctrl_one_r, ctrl_one_nxt;
  logic [7:0] ctrl_two_r, ctrl_two_nxt;
  logic [9:0] result_r, result_nxt;
  logic enable_r, enable_nxt;
  logic go_r, go_nxt;
  logic [7:0] rdata_nxt;
  acf_state_type state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [9:0] sar_r, sar_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] pos_ref_nxt, neg_ref_nxt;
  logic hold_connect_nxt, hold_discharge_nxt, sar_active_nxt;

  logic tick;
  logic rc_sel;
  logic trig;
  logic [7:0] fmt_high, fmt_low;
  logic [4:0] acq_periods;
  logic sw_go_set, sw_go_clr;

  function automatic logic [4:0] acq_decode(input logic [2:0] code);
    unique case (code)
      3'h0: acq_decode = 5'd0;
      3'h1: acq_decode = 5'd2;
      3'h2: acq_decode = 5'd4;
      3'h3: acq_decode = 5'd6;
      3'h4: acq_decode = 5'd8;
      3'h5: acq_decode = 5'd12;
      3'h6: acq_decode = 5'd16;
      default: acq_decode = 5'd20;
    endcase
  endfunction

  acf_clock_div u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sel_i(ctrl_two_r[acf_pkg::CLK_LSB +: 3]),
    // held in restart through the start delay too, so that delay is not swallowed by the first period
    .restart_i(state_r == ST_IDLE || state_r == ST_START),
    .tick_o(tick),
    .rc_sel_o(rc_sel)
  );

  acf_format u_fmt (
    .result_i(result_r),
    .right_i(ctrl_two_r[acf_pkg::JUSTIFY_BIT]),
    .high_o(fmt_high),
    .low_o(fmt_low)
  );

  assign acq_periods = acq_decode(ctrl_two_r[acf_pkg::ACQ_LSB +: 3]);
  assign trig = ctrl_one_r[acf_pkg::TRIG_SEL_BIT] ? charge_time_unit_trig_i
                                                  : capture_compare_unit_five_trig_i;
  assign sw_go_set = wr_i && addr_i == acf_pkg::OFS_RUN_CTRL && wdata_i[acf_pkg::RUN_GO_BIT];
  assign sw_go_clr = wr_i && addr_i == acf_pkg::OFS_RUN_CTRL && !wdata_i[acf_pkg::RUN_GO_BIT];

  // ==========================================================
  // register file
  always_comb begin
    ctrl_one_nxt = ctrl_one_r;
    ctrl_two_nxt = ctrl_two_r;
    enable_nxt = enable_r;
    if (wr_i) begin
      unique case (addr_i)
        acf_pkg::OFS_CTRL_ONE: ctrl_one_nxt = wdata_i & acf_pkg::CTRL_ONE_MASK;
        acf_pkg::OFS_CTRL_TWO: ctrl_two_nxt = wdata_i & acf_pkg::CTRL_TWO_MASK;
        acf_pkg::OFS_RUN_CTRL: enable_nxt = wdata_i[acf_pkg::RUN_ENABLE_BIT];
        default: ;
      endcase
    end
    rdata_nxt = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        acf_pkg::OFS_CTRL_ONE: rdata_nxt = ctrl_one_r;
        acf_pkg::OFS_CTRL_TWO: rdata_nxt = ctrl_two_r;
        acf_pkg::OFS_RES_HIGH: rdata_nxt = fmt_high;
        acf_pkg::OFS_RES_LOW: rdata_nxt = fmt_low;
        acf_pkg::OFS_RUN_CTRL: rdata_nxt = {6'h00, go_r, enable_r};
        acf_pkg::OFS_STATUS: rdata_nxt = {5'h00, 3'(state_r)};
        default: rdata_nxt = 8'h00;
      endcase
    end
    unique case (ctrl_one_r[acf_pkg::PREF_LSB +: 2])
      acf_pkg::PREF_EXT_PIN: pos_ref_nxt = acf_pkg::PREF_EXT_PIN;
      acf_pkg::PREF_FIXED_BUF: pos_ref_nxt = acf_pkg::PREF_FIXED_BUF;
      default: pos_ref_nxt = acf_pkg::PREF_SUPPLY;
    endcase
    neg_ref_nxt = (ctrl_one_r[acf_pkg::NREF_LSB +: 2] == acf_pkg::NREF_EXT_PIN)
                  ? acf_pkg::NREF_EXT_PIN : acf_pkg::NREF_GROUND;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_one_r <= acf_pkg::RST_CTRL_ONE;
      ctrl_two_r <= acf_pkg::RST_CTRL_TWO;
      enable_r <= 1'b0;
      rdata_o <= 8'h00;
      pos_ref_o <= acf_pkg::PREF_SUPPLY;
      neg_ref_o <= acf_pkg::NREF_GROUND;
    end else begin
      ctrl_one_r <= ctrl_one_nxt;
      ctrl_two_r <= ctrl_two_nxt;
      enable_r <= enable_nxt;
      rdata_o <= rdata_nxt;
      pos_ref_o <= pos_ref_nxt;
      neg_ref_o <= neg_ref_nxt;
    end
  end

  // ==========================================================
  // conversion sequencer
  always_comb begin
    state_nxt = state_r;
    go_nxt = go_r;
    cnt_nxt = cnt_r;
    sar_nxt = sar_r;
    bit_nxt = bit_r;
    result_nxt = result_r;
    if (state_r == ST_IDLE && enable_r && (sw_go_set || trig)) begin
      go_nxt = 1'b1;
      cnt_nxt = 5'(acf_pkg::INSTR_CYCLES);
      state_nxt = rc_sel ? ST_START : ST_ACQ;
      if (!rc_sel) cnt_nxt = acq_periods;
    end else if (go_r && (sw_go_clr || !enable_r)) begin
      // abort leaves the result untouched
      go_nxt = 1'b0;
      state_nxt = ST_GAP;
      cnt_nxt = 5'(acf_pkg::GAP_PERIODS);
    end else begin
      unique case (state_r)
        ST_IDLE: ;
        ST_START: begin
          cnt_nxt = cnt_r - 5'd1;
          if (cnt_r <= 5'd1) begin
            state_nxt = ST_ACQ;
            cnt_nxt = acq_periods;
          end
        end
        ST_ACQ: begin
          if (cnt_r == 5'd0) begin
            state_nxt = ST_CONV;
            sar_nxt = 10'h200;
            bit_nxt = 4'(acf_pkg::RESULT_BITS - 1);
          end else if (tick) begin
            cnt_nxt = cnt_r - 5'd1;
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (!compare_i) sar_nxt[bit_r] = 1'b0;
            if (bit_r == 4'd0) begin
              result_nxt = compare_i ? sar_r : (sar_r & ~10'h001);
              go_nxt = 1'b0;
              state_nxt = ST_GAP;
              cnt_nxt = 5'(acf_pkg::GAP_PERIODS);
            end else begin
              sar_nxt[bit_r - 4'd1] = 1'b1;
              bit_nxt = bit_r - 4'd1;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            cnt_nxt = cnt_r - 5'd1;
            if (cnt_r <= 5'd1) state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    // capacitor on the input from go until the conversion starts, discharged in the gap
    hold_connect_nxt = (state_nxt == ST_START) || (state_nxt == ST_ACQ);
    hold_discharge_nxt = (state_nxt == ST_GAP);
    sar_active_nxt = (state_nxt == ST_CONV);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      go_r <= 1'b0;
      cnt_r <= 5'd0;
      sar_r <= 10'h000;
      bit_r <= 4'd0;
      result_r <= 10'h000;
      hold_connect_o <= 1'b0;
      hold_discharge_o <= 1'b0;
      sar_active_o <= 1'b0;
      sar_trial_o <= 10'h000;
      go_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      go_r <= go_nxt;
      cnt_r <= cnt_nxt;
      sar_r <= sar_nxt;
      bit_r <= bit_nxt;
      result_r <= result_nxt;
      hold_connect_o <= hold_connect_nxt;
      hold_discharge_o <= hold_discharge_nxt;
      sar_active_o <= sar_active_nxt;
      sar_trial_o <= sar_nxt;
      go_o <= go_nxt;
    end
  end

  // ==========================================================
  // assertions
  AST_TRIG_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!enable_r && state_r == ST_IDLE) |=> !go_r) else $error("go set while disabled");
  AST_RESERVED_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_one_r & ~acf_pkg::CTRL_ONE_MASK) == 8'h00) else $error("reserved bits set");
  AST_RESERVED_TWO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_two_r[6] == 1'b0) else $error("reserved bit six set");
  AST_HOLD_ACQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_ACQ) |-> hold_connect_o) else $error("capacitor off during acquisition");
  AST_GO_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_CONV) |-> go_r) else $error("go low while converting");
  AST_ABORT_KEEPS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (go_r && sw_go_clr) |=> $stable(result_r)) else $error("abort changed result");
  AST_GAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(go_r) |-> state_r == ST_GAP) else $error("no gap after end");
  AST_DISCHARGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_GAP) |-> hold_discharge_o) else $error("capacitor not discharged");
  AST_RIGHT_FMT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_two_r[7] |-> (fmt_high[7:2] == 6'h00 && {fmt_high[1:0], fmt_low} == result_r))
    else $error("right format wrong");
  AST_RESULT_ONLY_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r != ST_CONV) |=> $stable(result_r)) else $error("result written early");
  AST_LEFT_FMT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_two_r[7] |-> (fmt_high == result_r[9:2] && fmt_low == {result_r[1:0], 6'h00}))
    else $error("left format wrong");
  AST_POS_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pos_ref_o == (($past(ctrl_one_r[3:2]) == 2'h3) ? 2'h0 : $past(ctrl_one_r[3:2])))
    else $error("positive reference routed wrong");
  AST_NEG_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    neg_ref_o == (($past(ctrl_one_r[1:0]) == 2'h1) ? 2'h1 : 2'h0))
    else $error("negative reference routed wrong");
  AST_RC_DELAY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($rose(go_r) && rc_sel) |-> (state_r == ST_START) [*4]) else $error("start delay too short");
  AST_HOLD_CONV: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_CONV) |-> (!hold_connect_o && !hold_discharge_o))
    else $error("capacitor switched during conversion");
  AST_ACQ_TICKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_ACQ && cnt_r != 5'd0 && !tick && enable_r && !sw_go_clr) |=> $stable(cnt_r))
    else $error("acquisition count moved without a conversion clock period");
  AST_TRIG_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_IDLE && !sw_go_set
     && !(ctrl_one_r[7] ? charge_time_unit_trig_i : capture_compare_unit_five_trig_i)) |=> !go_r)
    else $error("unselected trigger started a conversion");
  AST_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_r == ST_CONV && tick && bit_r == 4'd0 && enable_r && !sw_go_clr)
    |=> (!go_r && state_r == ST_GAP && result_r[0] == $past(compare_i)))
    else $error("go not cleared or last bit not stored at completion");
  COV_CONVERT: cover property (@(posedge clk_i) disable iff (!rst_n_i) state_r == ST_CONV ##1 state_r == ST_GAP);
  COV_ABORT: cover property (@(posedge clk_i) disable iff (!rst_n_i) go_r && sw_go_clr);
  COV_RC: cover property (@(posedge clk_i) disable iff (!rst_n_i) state_r == ST_START);
  COV_TRIGGER: cover property (@(posedge clk_i) disable iff (!rst_n_i) state_r == ST_IDLE && enable_r && trig);
  COV_RIGHT: cover property (@(posedge clk_i) disable iff (!rst_n_i) ctrl_two_r[7] && $fell(sar_active_o));
endmodule
`default_nettype wire

// ---- rtl/acf_format.sv ----
// result formatter: lays the 10-bit result into two bytes
`timescale 1ns/100ps
`default_nettype none
module acf_format (
  input wire logic [9:0] result_i,
  input wire logic right_i,
  output logic [7:0] high_o,
  output logic [7:0] low_o
);
  always_comb begin
    if (right_i) begin
      high_o = {6'h00, result_i[9:8]};
      low_o = result_i[7:0];
    end else begin
      high_o = result_i[9:2];
      low_o = {result_i[1:0], 6'h00};
    end
  end
endmodule
`default_nettype wire

// ---- rtl/acf_pkg.sv ----
// package: register map, field layout, encodings and timing of the converter control block
package acf_pkg;
  // ==========================================================
  // register indices (byte addresses on the plain port)
  localparam logic [2:0] OFS_CTRL_ONE = 3'h0;
  localparam logic [2:0] OFS_CTRL_TWO = 3'h1;
  localparam logic [2:0] OFS_RES_HIGH = 3'h2;
  localparam logic [2:0] OFS_RES_LOW = 3'h3;
  localparam logic [2:0] OFS_RUN_CTRL = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  // ==========================================================
  // field positions
  localparam int TRIG_SEL_BIT = 7;
  localparam int PREF_LSB = 2;
  localparam int NREF_LSB = 0;
  localparam int JUSTIFY_BIT = 7;
  localparam int ACQ_LSB = 3;
  localparam int CLK_LSB = 0;
  localparam int RUN_ENABLE_BIT = 0;
  localparam int RUN_GO_BIT = 1;
  localparam logic [7:0] CTRL_ONE_MASK = 8'h8F;
  localparam logic [7:0] CTRL_TWO_MASK = 8'hBF;
  localparam logic [7:0] RUN_MASK = 8'h03;
  // ==========================================================
  // reference routing codes
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_EXT_PIN = 2'h1;
  localparam logic [1:0] PREF_FIXED_BUF = 2'h2;
  localparam logic [1:0] NREF_GROUND = 2'h0;
  localparam logic [1:0] NREF_EXT_PIN = 2'h1;
  // ==========================================================
  // timing
  localparam int RESULT_BITS = 10;
  localparam int GAP_PERIODS = 2;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int RC_FREQ_HZ = 600_000;
  localparam int RC_DIV = CLK_FREQ_HZ / RC_FREQ_HZ;
  localparam int INSTR_CYCLE_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    REF_SEL_A,
    REF_SEL_B,
    REF_SEL_C
  } acf_ref_type;
endpackage
